/* dv/terminal_io_controller_checker.sv */
// Port assertions of the terminal I/O controller.
`timescale 1ns/10ps
`include "term_ctrl_regs.svh"

// ****************************************************************
// Checker module.
// ****************************************************************
module terminal_io_controller_checker (
    input wire logic                  clock,        // System clock.
    input wire logic                  rst,          // Synchronous reset.
    input wire logic                  rdCmd,        // Read-direct strobe.
    input wire logic [`TC_WORD_W-1:0] rdData,       // Returned character.
    input wire logic                  wrCmd,        // Write-direct strobe.
    input wire logic [`TC_WORD_W-1:0] wrData,       // Character from stack.
    input wire logic                  intReq,       // Interrupt request.
    input wire logic                  intAck,       // Interrupt serviced.
    input wire logic                  launchCmd,    // Launch strobe.
    input wire logic [`TC_WORD_W-1:0] launchAddr,   // Program address.
    input wire logic                  tableWr,      // Table write strobe.
    input wire logic [`TC_WORD_W-1:0] tablePtr,     // Table pointer.
    input wire logic                  svcReq,       // Channel service request.
    input wire logic                  chanCmd,      // Channel command strobe.
    input wire logic                  memInReady,   // Memory word taken.
    input wire logic                  memOutValid,  // Word toward memory.
    input wire logic                  blockDone,    // Block complete.
    input wire logic                  termTxStart,  // Print start.
    input wire logic [`TC_CHAR_W-1:0] termTxChar,   // Printed character.
    input wire logic                  termWordIn,   // Peripheral offers a word.
    input wire logic                  termWordTake  // Peripheral word taken.
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Launch, table entry and channel request must line up cycle for cycle.
    a_table_pointer: assert property (tableWr |-> $past(launchCmd) && tablePtr == $past(launchAddr))
        else $error("table pointer not taken from launch");
    a_table_svc: assert property (tableWr |-> svcReq)
        else $error("no service request after launch");
    a_svc_drop: assert property (svcReq && chanCmd |=> !svcReq)
        else $error("service request kept after command");
    a_svc_idle: assert property (svcReq |-> !memOutValid && !memInReady)
        else $error("data moves before channel command");
    a_take_offer: assert property (termWordTake |-> termWordIn)
        else $error("word taken that was not offered");
    a_done_pulse: assert property (blockDone |=> !blockDone)
        else $error("block done longer than one cycle");

    // Direct transfers and the shared request.
    a_tx_char: assert property (termTxStart |-> $past(wrCmd) && {8'h00, termTxChar} == ($past(wrData) & 16'h00FF))
        else $error("printed character differs from stack");
    a_rd_zero: assert property (rdCmd |=> rdData[15:8] == 8'h00)
        else $error("returned character not zero extended");
    a_int_hold: assert property (intReq && !intAck |=> intReq)
        else $error("interrupt request lost before service");
endmodule : terminal_io_controller_checker

bind terminal_io_controller terminal_io_controller_checker u_chk (.*);

/* dv/terminal_io_controller_tb_top.sv */
// Self-checking testbench of the terminal I/O controller.
`timescale 1ns/10ps
`include "term_ctrl_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin numErrors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

// ****************************************************************
// Testbench top.
// ****************************************************************
module terminal_io_controller_tb_top;
    logic        clock = 1'b0, rst = 1'b1, ctlCmd = 1'b0, rdCmd = 1'b0, wrCmd = 1'b0, intAck = 1'b0;
    logic        launchCmd = 1'b0, chanCmd = 1'b0, chanIsWrite = 1'b0, chanIntCmd = 1'b0, slow = 1'b0;
    logic        memInValid = 1'b0, memOutReady = 1'b0;
    logic [15:0] ctlWord = 16'h0000, wrData = 16'h0000, launchAddr = 16'h0000, chanLen = 16'h0000;
    logic [15:0] memInData = 16'h0000, feedLen = 16'h0000, inLen = 16'h0000, inIdx = 16'h0000;
    logic [7:0]  nextChar = 8'h41, termRxChar, termTxChar;
    logic [15:0] rdData, tablePtr, memOutData, termWordData, termWordQ;
    logic        intReq, tableWr, svcReq, memInReady, memOutValid, blockDone, termRdArm, termRxValid;
    logic        termTxStart, termTxBusy, termWordIn, termWordTake, termWordOut;
    logic [15:0] got[$];
    int          numErrors = 0, checked = 0;

    always #2.5 clock = ~clock;

    terminal_io_controller u_dut (.*);
    terminal_model u_term (.*);

    // Memory side: words toward memory are logged, words from memory are fed on the falling edge.
    always @(posedge clock)
    begin
        if (memOutValid && memOutReady)
            got.push_back(memOutData);
        if (memInValid && memInReady)
            inIdx <= inIdx + 16'h0001;
    end
    always @(negedge clock)
    begin
        memInValid <= inIdx < inLen;
        memInData <= 16'hC000 + inIdx;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    // A direct control command; the registered answer is visible on return.
    task automatic ctl(input logic [15:0] w);
        ctlWord = w;
        ctlCmd = 1'b1;
        tick(1);
        ctlCmd = 1'b0;
    endtask : ctl

    task automatic launch(input logic [15:0] a, input logic w, input logic [15:0] n, input logic ic);
        launchAddr = a;
        launchCmd = 1'b1;
        tick(1);
        launchCmd = 1'b0;
        `CHK("tableWr", 1'b1, tableWr)
        `CHK("tablePtr", a, tablePtr)
        tick(5);
        `CHK("svcReq", 1'b1, svcReq)
        chanIsWrite = w;
        chanLen = n;
        chanIntCmd = ic;
        chanCmd = 1'b1;
        tick(1);
        chanCmd = 1'b0;
        `CHK("svcDrop", 1'b0, svcReq)
    endtask : launch

    // Keys arrive fast then slow; each is held until read, then the terminal is rearmed.
    task automatic test_read();
        ctl(16'h0001);
        `CHK("arm", 1'b1, termRdArm)
        for (int j = 0; j < 2; j++)
        begin
            for (int i = 0; i < 40 && intReq !== 1'b1; i++) tick(1);
            `CHK("rxIrq", 1'b1, intReq)
            tick(12);
            `CHK("irqHold", 1'b1, intReq)
            nextChar = 8'h42;
            slow = 1'b1;
            rdCmd = 1'b1;
            intAck = 1'b1;
            tick(1);
            rdCmd = 1'b0;
            intAck = 1'b0;
            `CHK("rdData", {8'h00, 8'h41 + j[7:0]}, rdData)
            `CHK("rearm", 1'b1, termRdArm)
            `CHK("ackClr", 1'b0, intReq)
        end
        ctl(16'h0000);
        tick(40);
        `CHK("rdOff", 1'b0, intReq)
        $display("test_read done");
    endtask : test_read

    // Three characters printed, each completion asking for the next; then a refused write.
    task automatic test_write();
        slow = 1'b0;
        ctl(16'h0002);
        `CHK("wrIrq", 1'b1, intReq)
        for (int j = 0; j < 3; j++)
        begin
            wrData = 16'h0050 + j[15:0];
            wrCmd = 1'b1;
            intAck = 1'b1;
            tick(1);
            wrCmd = 1'b0;
            intAck = 1'b0;
            `CHK("txStart", 1'b1, termTxStart)
            `CHK("txChar", 8'h50 + j[7:0], termTxChar)
            `CHK("irqClr", 1'b0, intReq)
            for (int i = 0; i < 40 && intReq !== 1'b1; i++) tick(1);
            `CHK("txIrq", 1'b1, intReq)
            `CHK("printed", 8'h50 + j[7:0], u_term.txLog)
            slow = 1'b1;
        end
        intAck = 1'b1;
        ctl(16'h0000);
        intAck = 1'b0;
        wrCmd = 1'b1;
        tick(1);
        wrCmd = 1'b0;
        `CHK("wrOff", 1'b0, termTxStart)
        $display("test_write done");
    endtask : test_write

    // Twenty words toward memory with memory stalled until the buffer refuses.
    task automatic test_prog_read();
        feedLen = 16'h0014;
        launch(16'h1234, 1'b0, 16'h0014, 1'b1);
        tick(60);
        `CHK("fifoFull", 16, u_term.wordIdx)
        memOutReady = 1'b1;
        for (int i = 0; i < 100 && blockDone !== 1'b1; i++) tick(1);
        `CHK("done", 1'b1, blockDone)
        `CHK("doneIrq", 1'b1, intReq)
        `CHK("count", 20, got.size())
        foreach (got[i]) `CHK("word", 16'hA000 + i[15:0], got[i])
        intAck = 1'b1;
        tick(1);
        intAck = 1'b0;
        $display("test_prog_read done");
    endtask : test_prog_read

    // Three words from memory to the peripheral, no interrupt commanded.
    task automatic test_prog_write();
        inLen = 16'h0003;
        launch(16'h2000, 1'b1, 16'h0003, 1'b0);
        for (int i = 0; i < 100 && blockDone !== 1'b1; i++) tick(1);
        `CHK("done", 1'b1, blockDone)
        tick(1);
        `CHK("noIrq", 1'b0, intReq)
        `CHK("count", 3, u_term.outLog.size())
        foreach (u_term.outLog[i]) `CHK("word", 16'hC000 + i[15:0], u_term.outLog[i])
        $display("test_prog_write done");
    endtask : test_prog_write

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finishTest

    // Main sequence.
    initial
    begin
        tick(20);
        rst = 1'b0;
        tick(3);
        test_read();
        test_write();
        test_prog_read();
        test_prog_write();
        finishTest();
    end

    // Watchdog: the tests need a few hundred cycles, so four thousand means a hang.
    initial
    begin
        #20000;
        numErrors++;
        finishTest();
    end
endmodule : terminal_io_controller_tb_top

/* dv/terminal_model.sv */
// Behavioural terminal and block peripheral facing the controller.
`timescale 1ns/10ps

// ****************************************************************
// Terminal model.
// ****************************************************************
module terminal_model (
    input  wire logic        clock,        // System clock.
    input  wire logic        rst,          // Reset.
    input  wire logic        termRdArm,    // Arm for one key.
    input  wire logic [7:0]  nextChar,     // Key to be pressed.
    input  wire logic        slow,         // Slow key and print timing.
    input  wire logic        termTxStart,  // Print request.
    input  wire logic [7:0]  termTxChar,   // Character to print.
    input  wire logic        termWordTake, // Block word taken.
    input  wire logic [15:0] feedLen,      // Block words on offer.
    input  wire logic        termWordOut,  // Block word arrives.
    input  wire logic [15:0] termWordQ,    // That word.
    output logic             termRxValid,  // Key character held.
    output logic      [7:0]  termRxChar,   // Key character.
    output logic             termTxBusy,   // Printing.
    output logic             termWordIn,   // Block word offered.
    output logic      [15:0] termWordData  // Offered word.
);
    int          rxCnt;
    int          holdCnt;
    int          txCnt;
    int          wordIdx;
    logic [7:0]  txLog;
    logic [15:0] outLog[$];

    // One key per arm; the line drops and inverts later so a stale key cannot be read again.
    always @(posedge clock)
    begin
        if (rst)
        begin
            rxCnt <= 0;
            holdCnt <= 0;
            termRxValid <= 1'b0;
            termRxChar <= 8'h00;
        end
        else if (termRdArm)
        begin
            termRxValid <= 1'b0;
            holdCnt <= 0;
            rxCnt <= slow ? 15 : 3;
        end
        else if (rxCnt == 1)
        begin
            termRxValid <= 1'b1;
            termRxChar <= nextChar;
            rxCnt <= 0;
            holdCnt <= 8;
        end
        else
        begin
            if (rxCnt > 1)
                rxCnt <= rxCnt - 1;
            if (holdCnt == 1)
            begin
                termRxValid <= 1'b0;
                termRxChar <= ~termRxChar;
            end
            if (holdCnt > 0)
                holdCnt <= holdCnt - 1;
        end
    end

    // Printing stays busy for a while; its fall marks completion.
    always @(posedge clock)
    begin
        if (rst)
        begin
            txCnt <= 0;
            termTxBusy <= 1'b0;
        end
        else if (termTxStart)
        begin
            txLog <= termTxChar;
            txCnt <= slow ? 15 : 3;
            termTxBusy <= 1'b1;
        end
        else if (txCnt > 0)
        begin
            txCnt <= txCnt - 1;
            termTxBusy <= txCnt != 1;
        end
    end

    // Block words are offered while some remain; a released line holds the inverse of 16'h9FFF plus the word count.
    assign termWordIn = wordIdx < int'(feedLen);
    assign termWordData = termWordIn ? 16'hA000 + wordIdx[15:0] : ~(16'h9FFF + wordIdx[15:0]);

    // Count taken words and log everything the controller sends out.
    always @(posedge clock)
    begin
        if (rst)
            wordIdx <= 0;
        else if (termWordTake)
            wordIdx <= wordIdx + 1;
        if (termWordOut)
            outLog.push_back(termWordQ);
    end
endmodule : terminal_model

/* rtl/term_ctrl_pkg.sv */
// Types of the terminal I/O controller.
package term_ctrl_pkg;
    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_REQ,
        PROG_XFER,
        PROG_DONE
    } prog_state_t;
endpackage : term_ctrl_pkg

/* rtl/term_ctrl_regs.svh */
// Constants of the terminal I/O controller: widths, codes and timing counts.
`ifndef TERM_CTRL_REGS_SVH
`define TERM_CTRL_REGS_SVH
`define TC_CHAR_W        8
`define TC_WORD_W        16
`define TC_LEN_W         16
`define TC_FIFO_DEPTH    16
`define TC_FIFO_AW       4
`define TC_SYNC_GAP      2'd2
`define TC_CTL_RD_EN     0
`define TC_CTL_WR_EN     1
`define TC_CTL_RD_RST    1'b0
`define TC_CTL_WR_RST    1'b0
`endif

/* rtl/terminal_io_controller.sv */
// Terminal I/O controller with direct character mode and programmed block mode.
`timescale 1ns/10ps
`include "term_ctrl_regs.svh"

// ****************************************************************
// Word FIFO in the programmed data path.
// ****************************************************************
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clock,    // System clock.
    input  wire logic             rst,      // Synchronous reset, active high.
    input  wire logic             inValid,  // Write side offers a word.
    output logic                  inReady,  // FIFO has room.
    input  wire logic [WIDTH-1:0] inData,   // Word written.
    output logic                  outValid, // FIFO holds a word.
    input  wire logic             outReady, // Read side takes the word.
    output logic      [WIDTH-1:0] outData   // Oldest word.
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0]      count_reg, count_next;
    logic             doWr, doRd;

    // Full and empty come straight from the occupancy count.
    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem_reg[rdPtr_reg];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;

    // Pointer and count update.
    always_comb
    begin
        wrPtr_next = doWr ? wrPtr_reg + AW'(1) : wrPtr_reg;
        rdPtr_next = doRd ? rdPtr_reg + AW'(1) : rdPtr_reg;
        count_next = count_reg;
        if (doWr && !doRd)
        begin
            count_next = count_reg + (AW+1)'(1);
        end
        else if (doRd && !doWr)
        begin
            count_next = count_reg - (AW+1)'(1);
        end
    end

    // Storage has no reset; only valid slots are ever read.
    always_ff @(posedge clock)
    begin
        if (doWr)
        begin
            mem_reg[wrPtr_reg] <= inData;
        end
        if (rst)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end
endmodule : word_fifo

// ****************************************************************
// Controller top.
// ****************************************************************
// Notes on behaviour
// - Direction enables come from control command
// - Read enable arms terminal for one character
// - Arriving character raises interrupt request
// - Read-direct returns character, rearms terminal
// - Write enable raises interrupt for first character
// - Write-direct character sent to terminal autonomously
// - Write completion raises next-character interrupt
// - Direct transfers bypass channels entirely
// - Launch loads device table program pointer
// - Controller requests channel service; commands on demand
// - Block transfer length taken from command
// - Program-commanded interrupt after block completes
module terminal_io_controller
    import term_ctrl_pkg::*;
(
    input  wire logic                    clock,        // 200 MHz system clock.
    input  wire logic                    rst,          // Synchronous reset, active high.
    // Direct commands from the I/O processor.
    input  wire logic                    ctlCmd,       // Control-direct command strobe.
    input  wire logic [`TC_WORD_W-1:0]   ctlWord,      // Control word carried by it.
    input  wire logic                    rdCmd,        // Read-direct command strobe.
    output logic      [`TC_WORD_W-1:0]   rdData,       // Character returned to stack.
    input  wire logic                    wrCmd,        // Write-direct command strobe.
    input  wire logic [`TC_WORD_W-1:0]   wrData,       // Character from stack.
    output logic                         intReq,       // Interrupt request to processor.
    input  wire logic                    intAck,       // Processor services interrupt.
    // Programmed transfers.
    input  wire logic                    launchCmd,    // Program launch command strobe.
    input  wire logic [`TC_WORD_W-1:0]   launchAddr,   // First program word address.
    output logic                         tableWr,      // Device table entry write strobe.
    output logic      [`TC_WORD_W-1:0]   tablePtr,     // Pointer written to the entry.
    output logic                         svcReq,       // Service request to channel.
    input  wire logic                    chanCmd,      // Channel delivers a program command.
    input  wire logic                    chanIsWrite,  // Command direction: to memory is 0.
    input  wire logic [`TC_LEN_W-1:0]    chanLen,      // Block length in words.
    input  wire logic                    chanIntCmd,   // Program commands an interrupt.
    input  wire logic                    memInValid,   // Word from memory buffer.
    output logic                         memInReady,   // Controller takes that word.
    input  wire logic [`TC_WORD_W-1:0]   memInData,    // Memory word.
    output logic                         memOutValid,  // Word toward memory buffer.
    input  wire logic                    memOutReady,  // Memory takes that word.
    output logic      [`TC_WORD_W-1:0]   memOutData,   // Word for memory.
    output logic                         blockDone,    // Block complete pulse.
    // Terminal side, pins from another domain.
    output logic                         termRdArm,    // Arm terminal for one character.
    input  wire logic                    termRxValid,  // Terminal holds a character (level).
    input  wire logic [`TC_CHAR_W-1:0]   termRxChar,   // Received character.
    output logic                         termTxStart,  // Start writing a character.
    output logic      [`TC_CHAR_W-1:0]   termTxChar,   // Character to write.
    input  wire logic                    termTxBusy,   // Terminal writing (level).
    input  wire logic                    termWordIn,   // Peripheral offers a block word.
    input  wire logic [`TC_WORD_W-1:0]   termWordData, // Peripheral block word.
    output logic                         termWordTake, // Peripheral word taken.
    output logic                         termWordOut,  // Block word to peripheral valid.
    output logic      [`TC_WORD_W-1:0]   termWordQ     // Block word to peripheral.
);
    // Synchronised terminal levels; stage one is read only by stage two.
    logic [1:0] rxV_sync, txB_sync, wIn_sync;
    logic [`TC_CHAR_W-1:0] rxC_s1, rxC_s2;
    logic [`TC_WORD_W-1:0] wD_s1, wD_s2;
    logic rxV_d, txB_d;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rxV_sync <= '0;
            txB_sync <= '0;
            wIn_sync <= '0;
            rxC_s1   <= '0;
            rxC_s2   <= '0;
            wD_s1    <= '0;
            wD_s2    <= '0;
            rxV_d    <= 1'b0;
            txB_d    <= 1'b0;
        end
        else
        begin
            rxV_sync <= {rxV_sync[0], termRxValid};
            txB_sync <= {txB_sync[0], termTxBusy};
            wIn_sync <= {wIn_sync[0], termWordIn};
            rxC_s1   <= termRxChar;
            rxC_s2   <= rxC_s1;
            wD_s1    <= termWordData;
            wD_s2    <= wD_s1;
            rxV_d    <= rxV_sync[1];
            txB_d    <= txB_sync[1];
        end
    end

    logic rxRise, txFall;
    assign rxRise = rxV_sync[1] & ~rxV_d;
    assign txFall = txB_d & ~txB_sync[1];

    // ************************************************************
    // Direct mode, no channel path involved.
    // ************************************************************
    logic rdEn_reg, rdEn_next, wrEn_reg, wrEn_next;
    logic pend_reg, pend_next;
    logic arm_reg, arm_next, txGo_reg, txGo_next;
    logic [`TC_CHAR_W-1:0] hold_reg, hold_next, txC_reg, txC_next;
    logic [`TC_WORD_W-1:0] rdD_reg, rdD_next;
    logic progInt;

    // Each event sets the pending request; set beats acknowledge.
    always_comb
    begin
        rdEn_next = rdEn_reg;
        wrEn_next = wrEn_reg;
        arm_next  = 1'b0;
        txGo_next = 1'b0;
        hold_next = hold_reg;
        txC_next  = txC_reg;
        rdD_next  = rdD_reg;
        pend_next = pend_reg & ~intAck;
        if (ctlCmd)
        begin
            rdEn_next = ctlWord[`TC_CTL_RD_EN];
            wrEn_next = ctlWord[`TC_CTL_WR_EN];
            if (ctlWord[`TC_CTL_RD_EN] && !rdEn_reg)
            begin
                arm_next = 1'b1;
            end
            if (ctlWord[`TC_CTL_WR_EN] && !wrEn_reg)
            begin
                pend_next = 1'b1;
            end
        end
        if (rxRise && rdEn_reg)
        begin
            hold_next = rxC_s2;
            pend_next = 1'b1;
        end
        if (rdCmd)
        begin
            rdD_next = {{(`TC_WORD_W-`TC_CHAR_W){1'b0}}, hold_reg};
            arm_next = rdEn_reg;
        end
        if (wrCmd && wrEn_reg)
        begin
            txC_next  = wrData[`TC_CHAR_W-1:0];
            txGo_next = 1'b1;
        end
        if (txFall && wrEn_reg)
        begin
            pend_next = 1'b1;
        end
        if (progInt)
        begin
            pend_next = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdEn_reg <= `TC_CTL_RD_RST;
            wrEn_reg <= `TC_CTL_WR_RST;
            pend_reg <= 1'b0;
            arm_reg  <= 1'b0;
            txGo_reg <= 1'b0;
            hold_reg <= '0;
            txC_reg  <= '0;
            rdD_reg  <= '0;
        end
        else
        begin
            rdEn_reg <= rdEn_next;
            wrEn_reg <= wrEn_next;
            pend_reg <= pend_next;
            arm_reg  <= arm_next;
            txGo_reg <= txGo_next;
            hold_reg <= hold_next;
            txC_reg  <= txC_next;
            rdD_reg  <= rdD_next;
        end
    end

    assign intReq      = pend_reg;
    assign rdData      = rdD_reg;
    assign termRdArm   = arm_reg;
    assign termTxStart = txGo_reg;
    assign termTxChar  = txC_reg;

    // ************************************************************
    // Programmed mode: launch, channel service, block transfer.
    // ************************************************************
    prog_state_t st_reg, st_next;
    logic [`TC_LEN_W-1:0] left_reg, left_next;
    logic dir_reg, dir_next, intOn_reg, intOn_next;
    logic tw_reg, tw_next, done_reg, done_next;
    logic [`TC_WORD_W-1:0] tp_reg, tp_next;
    logic inFire;
    logic [1:0] wGap_reg, wGap_next;

    // Words pass through the FIFO so a slow drain stalls the source.
    logic fInValid, fInReady, fOutValid, fOutReady;
    logic [`TC_WORD_W-1:0] fInData, fOutData;
    logic fromDev, wOk;
    assign wOk       = wIn_sync[1] && (wGap_reg == '0);
    assign fromDev   = (st_reg == PROG_XFER) && !dir_reg;
    assign fInValid  = (st_reg == PROG_XFER) && (left_reg != '0) && (dir_reg ? memInValid : wOk);
    assign fInData   = dir_reg ? memInData : wD_s2;
    assign inFire    = fInValid & fInReady;
    assign memInReady   = dir_reg && (st_reg == PROG_XFER) && (left_reg != '0) && fInReady;
    assign termWordTake = fromDev && (left_reg != '0) && wOk && fInReady;
    assign memOutValid  = !dir_reg & fOutValid;
    assign termWordOut  = dir_reg & fOutValid;
    assign fOutReady    = dir_reg ? 1'b1 : memOutReady;
    assign memOutData   = fOutData;
    assign termWordQ    = fOutData;

    word_fifo #(
        .WIDTH (`TC_WORD_W),
        .DEPTH (`TC_FIFO_DEPTH),
        .AW    (`TC_FIFO_AW)
    ) u_fifo (
        .clock    (clock),
        .rst      (rst),
        .inValid  (fInValid),
        .inReady  (fInReady),
        .inData   (fInData),
        .outValid (fOutValid),
        .outReady (fOutReady),
        .outData  (fOutData)
    );

    // Block sequencer.
    always_comb
    begin
        st_next    = st_reg;
        left_next  = left_reg;
        dir_next   = dir_reg;
        intOn_next = intOn_reg;
        tw_next    = 1'b0;
        done_next  = 1'b0;
        tp_next    = tp_reg;
        progInt    = 1'b0;
        wGap_next  = (wGap_reg != '0) ? wGap_reg - 2'd1 : 2'd0;
        if (termWordTake)
        begin
            wGap_next = `TC_SYNC_GAP;                        // Wait until the next word is through the synchroniser.
        end
        case (st_reg)
            PROG_IDLE:
            begin
                if (launchCmd)
                begin
                    tp_next = launchAddr;
                    tw_next = 1'b1;
                    st_next = PROG_REQ;
                end
            end
            PROG_REQ:
            begin
                if (chanCmd)
                begin
                    left_next  = chanLen;
                    dir_next   = chanIsWrite;
                    intOn_next = chanIntCmd;
                    st_next    = (chanLen == '0) ? PROG_DONE : PROG_XFER;
                end
            end
            PROG_XFER:
            begin
                if (inFire)
                begin
                    left_next = left_reg - `TC_LEN_W'(1);
                end
                if (left_reg == '0 && !fOutValid)
                begin
                    st_next = PROG_DONE;
                end
            end
            PROG_DONE:
            begin
                done_next = 1'b1;
                progInt   = intOn_reg;
                st_next   = PROG_IDLE;
            end
            default:
            begin
                st_next = PROG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st_reg    <= PROG_IDLE;
            left_reg  <= '0;
            dir_reg   <= 1'b0;
            intOn_reg <= 1'b0;
            tw_reg    <= 1'b0;
            done_reg  <= 1'b0;
            tp_reg    <= '0;
            wGap_reg  <= '0;
        end
        else
        begin
            st_reg    <= st_next;
            left_reg  <= left_next;
            dir_reg   <= dir_next;
            intOn_reg <= intOn_next;
            tw_reg    <= tw_next;
            done_reg  <= done_next;
            tp_reg    <= tp_next;
            wGap_reg  <= wGap_next;
        end
    end

    // Service is requested while waiting for the next program command.
    assign svcReq    = (st_reg == PROG_REQ);
    assign tableWr   = tw_reg;
    assign tablePtr  = tp_reg;
    assign blockDone = done_reg;
endmodule : terminal_io_controller
